// file: sdram_init_sequencer.sv
// Memory controller initialization path: register port, access port and memory command sequencer.
// Assumes the register and access ports on core_clk, the memory pins on memory_clock,
// and reset_n released while the memory clock may still be quiet.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps

module sdram_init_sequencer
   import sdram_init_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ready,
   output logic             mem_ack,
   output logic             mem_error,
   output logic      [31:0] mem_rdata,
   input  wire logic        memory_clock,
   output logic      [3:0]  domain_chip_select_n,
   output logic             row_strobe_n,
   output logic             column_strobe_n,
   output logic             write_enable_n,
   output logic      [15:0] mem_pin_addr,
   input  wire logic [31:0] data_in,
   output logic      [31:0] data_out,
   output logic             data_oe_n
);

   // ==========================================================
   // Core domain: software registers
   logic [2:0]          global_memory_control_reg;
   logic [REFCNT_W-1:0] refresh_interval_timer_reg;
   logic [3:0]          bus16_reg;
   logic [7:0]          casl_reg;
   logic                unmapped_err_reg;
   logic [31:0]         reg_rdata_reg;

   // Core domain: access and refresh-count handshakes
   logic                req_tog_reg;
   logic                done_seen_reg;
   logic                acc_write_reg;
   logic [31:0]         acc_addr_reg;
   logic [31:0]         acc_wdata_reg;
   logic                ack_reg;
   logic                err_reg;
   logic [31:0]         mem_rdata_reg;
   logic [REFCNT_W-1:0] ref_xfer_reg;
   logic                ref_tog_reg;
   logic [1:0]          back_sync;

   // Link domain registers
   logic [1:0]          link_rst_reg;
   link_state_t         state_reg,    state_next;
   mem_cmd_t            cmd_reg,      cmd_next;
   logic [3:0]          cs_n_reg,     cs_n_next;
   logic [15:0]         pin_addr_reg, pin_addr_next;
   logic [31:0]         dout_reg,     dout_next;
   logic                oe_n_reg,     oe_n_next;
   logic [1:0]          cnt_reg,      cnt_next;
   logic                pre_done_reg, pre_done_next;
   logic                done_tog_reg, done_tog_next;
   logic [31:0]         link_rdata_reg, link_rdata_next;
   logic [REFCNT_W-1:0] link_refcnt_reg;
   logic                ref_ack_reg;
   logic                ref_pending_reg;
   logic                ref_clear;
   logic                refresh_tick;
   logic [16:0]         fwd_sync;

   // ==========================================================
   // Core domain decode
   wire        access_busy   = (req_tog_reg != back_sync[0]);
   wire        ref_busy      = (ref_tog_reg != back_sync[1]);
   wire        acc_take      = mem_req && mem_ready;
   wire        acc_mapped    = (mem_addr[31:30] == DOMAIN_TOP_BITS);
   wire        done_event    = (back_sync[0] != done_seen_reg);
   wire        wr_ctrl       = reg_write && (reg_addr == GLOBAL_CTRL_OFFSET);
   wire        wr_status     = reg_write && (reg_addr == STATUS_OFFSET);
   wire        wr_refresh    = reg_write && (reg_addr == REFRESH_OFFSET);
   wire        cfg_hit       = (reg_addr[7:4] == DEVCFG_BASE_OFFSET[7:4]) && (reg_addr[1:0] == 2'h0);
   wire [1:0]  cfg_idx       = reg_addr[3:2];
   wire        wr_cfg        = reg_write && cfg_hit;
   wire        err_clear     = wr_status && reg_wdata[STAT_UNMAPPED_BIT];
   wire        err_set       = acc_take && !acc_mapped;

   // Read multiplexer; unmapped offsets read as zero
   wire [31:0] cfg_word      = {26'h0, casl_reg[2*cfg_idx +: 2], 1'b0, bus16_reg[cfg_idx], 2'h0};
   wire [31:0] status_word   = {29'h0, unmapped_err_reg, ref_busy, access_busy};
   wire [31:0] read_mux      = (reg_addr == GLOBAL_CTRL_OFFSET) ? {29'h0, global_memory_control_reg} :
                               (reg_addr == STATUS_OFFSET)      ? status_word :
                               (reg_addr == REFRESH_OFFSET)     ? {16'h0, refresh_interval_timer_reg} :
                               cfg_hit                          ? cfg_word : 32'h0000_0000;

   // One access at a time; a new request can be taken at the same edge that raises the previous answer
   assign mem_ready = !access_busy && !ack_reg;

   // ==========================================================
   // Software register writes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         global_memory_control_reg  <= CTRL_RESET;
         refresh_interval_timer_reg <= REFCNT_RESET;
         bus16_reg                  <= {4{DEVCFG_BUS16_RESET}};
         casl_reg                   <= {4{DEVCFG_CASL_RESET}};
         unmapped_err_reg           <= 1'b0;
         reg_rdata_reg              <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctrl)
            global_memory_control_reg <= reg_wdata[2:0];
         if (wr_refresh)
            refresh_interval_timer_reg <= reg_wdata[15:0];
         if (wr_cfg)
         begin
            bus16_reg[cfg_idx]       <= reg_wdata[DEVCFG_BUS16_BIT];
            casl_reg[2*cfg_idx +: 2] <= reg_wdata[DEVCFG_CASL_LSB +: 2];
         end
         // Hardware set beats the software clear in the same cycle
         unmapped_err_reg <= err_set || (unmapped_err_reg && !err_clear);
         reg_rdata_reg    <= reg_read ? read_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Access request hand-off; unmapped addresses answer at once
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_tog_reg   <= 1'b0;
         done_seen_reg <= 1'b0;
         acc_write_reg <= 1'b0;
         acc_addr_reg  <= 32'h0000_0000;
         acc_wdata_reg <= 32'h0000_0000;
         ack_reg       <= 1'b0;
         err_reg       <= 1'b0;
         mem_rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= done_event || err_set;
         err_reg <= err_set;
         if (acc_take && acc_mapped)
         begin
            req_tog_reg   <= !req_tog_reg;
            acc_write_reg <= mem_write;
            acc_addr_reg  <= mem_addr;
            acc_wdata_reg <= mem_wdata;
         end
         if (done_event)
         begin
            done_seen_reg <= back_sync[0];
            mem_rdata_reg <= link_rdata_reg;
         end
         else if (err_set)
            mem_rdata_reg <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Refresh count hand-off; the word is held until the far side echoes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ref_xfer_reg <= REFCNT_RESET;
         ref_tog_reg  <= 1'b0;
      end
      else if (!ref_busy && (ref_xfer_reg != refresh_interval_timer_reg))
      begin
         ref_xfer_reg <= refresh_interval_timer_reg;
         ref_tog_reg  <= !ref_tog_reg;
      end
   end

   level_sync3 #(.WIDTH(2), .INIT_VAL(2'h0)) u_back_sync (
      .clk      (core_clk),
      .rst_n    (reset_n),
      .async_in ({ref_ack_reg, done_tog_reg}),
      .sync_out (back_sync)
   );

   assign reg_rdata = reg_rdata_reg;
   assign mem_ack   = ack_reg;
   assign mem_error = err_reg;
   assign mem_rdata = mem_rdata_reg;

   // ==========================================================
   // Link domain: reset release aligned to the memory clock
   always_ff @(posedge memory_clock or negedge reset_n)
   begin
      if (!reset_n)
         link_rst_reg <= 2'h0;
      else
         link_rst_reg <= {link_rst_reg[0], 1'b1};
   end

   wire link_rst_n = link_rst_reg[1];

   // Control and configuration bits are quasi-static, so per-bit crossing is enough
   level_sync3 #(.WIDTH(17), .INIT_VAL({2'h0, 8'hFF, 4'h0, CTRL_RESET})) u_fwd_sync (
      .clk      (memory_clock),
      .rst_n    (link_rst_n),
      .async_in ({ref_tog_reg, req_tog_reg, casl_reg, bus16_reg, global_memory_control_reg}),
      .sync_out (fwd_sync)
   );

   wire [2:0]  mode_bits   = fwd_sync[2:0];
   wire [3:0]  link_bus16  = fwd_sync[6:3];
   wire [7:0]  link_casl   = fwd_sync[14:7];
   wire        link_req    = fwd_sync[15];
   wire        link_ref    = fwd_sync[16];
   wire        is_normal   = (mode_bits == CMODE_NORMAL);
   wire        is_mode_set = (mode_bits == CMODE_MODE_SET);
   wire        is_prech    = (mode_bits == CMODE_PRECHARGE);
   wire        is_nop      = (mode_bits == CMODE_NOP);
   wire        req_pending = (link_req != done_tog_reg);

   // Domain select from the top address nibble; held access address is stable here
   wire [1:0]  dom_idx     = acc_addr_reg[29:28];
   wire [3:0]  dom_cs_n    = ~(4'h1 << dom_idx);
   wire        dom_bus16   = link_bus16[dom_idx];
   wire [1:0]  dom_casl    = link_casl[2*dom_idx +: 2];
   wire [3:0]  cs_idle_n   = is_nop ? 4'h0 : 4'hF;

   // Row/bank and column pin mapping per bus width
   wire [15:0] row_addr    = dom_bus16 ? {acc_addr_reg[27:26], acc_addr_reg[22:9]} :
                                         {acc_addr_reg[27:26], acc_addr_reg[23:10]};
   wire [15:0] col_addr    = dom_bus16 ?
      {acc_addr_reg[27:26], 3'h0, 1'b1, acc_addr_reg[25:24], acc_addr_reg[8:1]} :
      {acc_addr_reg[27:26], 3'h0, 1'b1, acc_addr_reg[25:24], acc_addr_reg[9:2]};
   wire [31:0] read_word   = dom_bus16 ? {16'h0, data_in[15:0]} : data_in;

   refresh_timer u_refresh_timer (
      .clk           (memory_clock),
      .rst_n         (link_rst_n),
      .refresh_count (link_refcnt_reg),
      .refresh_tick  (refresh_tick)
   );

   // ==========================================================
   // Command sequencer: precharge first, then refresh, then accesses
   always_comb
   begin
      state_next      = state_reg;
      cmd_next        = CMD_NOP;
      cs_n_next       = cs_idle_n;
      pin_addr_next   = pin_addr_reg;
      dout_next       = dout_reg;
      oe_n_next       = 1'b1;
      cnt_next        = cnt_reg;
      pre_done_next   = is_prech && pre_done_reg;
      done_tog_next   = done_tog_reg;
      link_rdata_next = link_rdata_reg;
      ref_clear       = 1'b0;
      unique case (state_reg)
         LS_IDLE:
         begin
            if (is_prech && !pre_done_reg)
            begin
               cmd_next      = CMD_PRECHARGE;
               cs_n_next     = 4'h0;
               pin_addr_next = 16'h1 << AUTO_PRECHARGE_BIT;
               pre_done_next = 1'b1;
            end
            else if (ref_pending_reg && (is_prech || is_normal))
            begin
               cmd_next  = CMD_REFRESH;
               cs_n_next = 4'h0;
               ref_clear = 1'b1;
            end
            else if (req_pending && is_normal)
            begin
               cmd_next      = CMD_ACTIVE;
               cs_n_next     = dom_cs_n;
               pin_addr_next = row_addr;
               state_next    = LS_RW;
            end
            else if (req_pending && is_mode_set)
            begin
               cmd_next        = CMD_MODE_SET;
               cs_n_next       = dom_cs_n;
               pin_addr_next   = row_addr;
               link_rdata_next = 32'h0000_0000;
               cnt_next        = MODE_SET_WAIT;
               state_next      = LS_WAIT;
            end
            else if (req_pending)
            begin
               // No memory cycle in NOP, precharge or unsupported modes
               link_rdata_next = 32'h0000_0000;
               state_next      = LS_DONE;
            end
         end
         LS_RW:
         begin
            cmd_next      = acc_write_reg ? CMD_WRITE : CMD_READ;
            cs_n_next     = dom_cs_n;
            pin_addr_next = col_addr;
            oe_n_next     = !acc_write_reg;
            dout_next     = acc_wdata_reg;
            cnt_next      = acc_write_reg ? WRITE_RECOVERY : dom_casl;
            state_next    = LS_WAIT;
         end
         LS_WAIT:
         begin
            cnt_next = cnt_reg - 2'h1;
            if (cnt_reg <= 2'h1)
            begin
               if (!acc_write_reg && is_normal)
                  link_rdata_next = read_word;
               state_next = LS_DONE;
            end
         end
         LS_DONE:
         begin
            done_tog_next = !done_tog_reg;
            state_next    = LS_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Link registers; pins always come straight from flip-flops
   always_ff @(posedge memory_clock or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         state_reg      <= LS_IDLE;
         cmd_reg        <= CMD_NOP;
         cs_n_reg       <= 4'hF;
         pin_addr_reg   <= 16'h0000;
         dout_reg       <= 32'h0000_0000;
         oe_n_reg       <= 1'b1;
         cnt_reg        <= 2'h0;
         pre_done_reg   <= 1'b0;
         done_tog_reg   <= 1'b0;
         link_rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         state_reg      <= state_next;
         cmd_reg        <= cmd_next;
         cs_n_reg       <= cs_n_next;
         pin_addr_reg   <= pin_addr_next;
         dout_reg       <= dout_next;
         oe_n_reg       <= oe_n_next;
         cnt_reg        <= cnt_next;
         pre_done_reg   <= pre_done_next;
         done_tog_reg   <= done_tog_next;
         link_rdata_reg <= link_rdata_next;
      end
   end

   // Refresh count capture and pending refresh; a new tick beats the clear
   always_ff @(posedge memory_clock or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         link_refcnt_reg <= REFCNT_RESET;
         ref_ack_reg     <= 1'b0;
         ref_pending_reg <= 1'b0;
      end
      else
      begin
         if (link_ref != ref_ack_reg)
         begin
            link_refcnt_reg <= ref_xfer_reg;
            ref_ack_reg     <= link_ref;
         end
         ref_pending_reg <= refresh_tick || (ref_pending_reg && !ref_clear);
      end
   end

   assign domain_chip_select_n = cs_n_reg;
   assign row_strobe_n         = cmd_reg[2];
   assign column_strobe_n      = cmd_reg[1];
   assign write_enable_n       = cmd_reg[0];
   assign mem_pin_addr         = pin_addr_reg;
   assign data_out             = dout_reg;
   assign data_oe_n            = oe_n_reg;

endmodule

// file: sdram_init_pkg.sv
// Constants, encodings and register layout of the memory initialization sequencer.
// Assumes a register port on the core clock and a memory side on the memory clock.

package sdram_init_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0]  GLOBAL_CTRL_OFFSET   = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET        = 8'h04;
   localparam logic [7:0]  REFRESH_OFFSET       = 8'h08;
   localparam logic [7:0]  DEVCFG_BASE_OFFSET   = 8'h10;

   // ==========================================================
   // Field positions and reset values
   localparam int          CTRL_INIT_BIT        = 0;
   localparam int          CTRL_MODE_SET_BIT    = 1;
   localparam int          CTRL_CMD_LOAD_BIT    = 2;
   localparam logic [2:0]  CTRL_RESET           = 3'h3;
   localparam int          STAT_ACCESS_BUSY_BIT = 0;
   localparam int          STAT_REF_LOAD_BIT    = 1;
   localparam int          STAT_UNMAPPED_BIT    = 2;
   localparam int          REFCNT_W             = 16;
   localparam logic [15:0] REFCNT_RESET         = 16'h0000;
   localparam int          DEVCFG_BUS16_BIT     = 2;
   localparam int          DEVCFG_CASL_LSB      = 4;
   localparam logic        DEVCFG_BUS16_RESET   = 1'b0;
   localparam logic [1:0]  DEVCFG_CASL_RESET    = 2'h3;
   localparam logic [1:0]  DOMAIN_TOP_BITS      = 2'h3;
   localparam int          AUTO_PRECHARGE_BIT   = 10;

   // ==========================================================
   // Timing counts in memory clock cycles
   localparam logic [1:0]  MODE_SET_WAIT        = 2'h3;
   localparam logic [1:0]  WRITE_RECOVERY       = 2'h2;
   localparam logic [15:0] REFRESH_PERIOD_TRIM  = 16'h0002;

   // ==========================================================
   // Control modes, coded as {command_load, mode_set, initialize}
   typedef enum logic [2:0] {
      CMODE_NORMAL    = 3'b000,
      CMODE_PRECHARGE = 3'b001,
      CMODE_MODE_SET  = 3'b010,
      CMODE_NOP       = 3'b011
   } ctrl_mode_t;

   // Memory commands, coded as {row strobe, column strobe, write enable}
   typedef enum logic [2:0] {
      CMD_MODE_SET    = 3'b000,
      CMD_REFRESH     = 3'b001,
      CMD_PRECHARGE   = 3'b010,
      CMD_ACTIVE      = 3'b011,
      CMD_WRITE       = 3'b100,
      CMD_READ        = 3'b101,
      CMD_NOP         = 3'b111
   } mem_cmd_t;

   // Memory side sequencer states
   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_RW   = 2'b01,
      LS_WAIT = 2'b10,
      LS_DONE = 2'b11
   } link_state_t;

endpackage

// file: level_sync3.sv
// Three-stage synchroniser for a group of slowly changing levels.
// Assumes each bit is independent; a multi-bit field is only coherent when quasi-static.
`timescale 1ns/100ps

module level_sync3
   import sdram_init_pkg::*;
#(
   parameter int               WIDTH    = 1,
   parameter logic [WIDTH-1:0] INIT_VAL = '0
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ==========================================================
   // Per-bit chain; output moves only when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_reg;
         logic s2_reg;
         logic s3_reg;
         logic out_reg;
         // First stage feeds nothing but the second stage
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_reg <= INIT_VAL[i];
               s2_reg   <= INIT_VAL[i];
               s3_reg   <= INIT_VAL[i];
               out_reg  <= INIT_VAL[i];
            end
            else
            begin
               meta_reg <= async_in[i];
               s2_reg   <= meta_reg;
               s3_reg   <= s2_reg;
               if (s2_reg == s3_reg)
                  out_reg <= s3_reg;
            end
         end
         assign sync_out[i] = out_reg;
      end
   endgenerate

endmodule

// file: refresh_timer.sv
// Auto refresh interval counter on the memory clock.
// Assumes the count value arrives already in the memory clock domain.
`timescale 1ns/100ps

module refresh_timer
   import sdram_init_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [REFCNT_W-1:0] refresh_count,
   output logic                     refresh_tick
);

   logic [REFCNT_W-1:0] cnt_reg;
   logic                tick_reg;
   wire                 timer_on   = (refresh_count >= REFRESH_PERIOD_TRIM);
   wire  [REFCNT_W-1:0] count_last = refresh_count - REFRESH_PERIOD_TRIM;
   wire                 expire     = timer_on && (cnt_reg >= count_last);

   // ==========================================================
   // Period is count minus one cycles; counts below two stop refresh
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= expire || !timer_on ? '0 : cnt_reg + 16'h0001;
         tick_reg <= expire;
      end
   end

   assign refresh_tick = tick_reg;

endmodule

// file: mem_model.sv
// Behavioural external memory: one stored word, read data after CAS latency 3.
// Assumes command pins registered on memory_clock.
`timescale 1ns/100ps
module mem_model
   import sdram_init_pkg::*;
(
   input  wire logic        memory_clock,
   input  wire logic [3:0]  domain_chip_select_n,
   input  wire logic [2:0]  cmd,
   input  wire logic [31:0] data_out,
   input  wire logic        data_oe_n,
   output logic      [31:0] data_in
);
   logic [31:0] word_reg = 32'h0;
   logic [2:0]  pipe_reg = 3'h0;
   wire  logic  sel = domain_chip_select_n != 4'hF;
   // Store written word, track read latency
   always @(posedge memory_clock)
   begin
      pipe_reg <= {pipe_reg[1:0], sel && cmd == CMD_READ};
      if (sel && cmd == CMD_WRITE && !data_oe_n)
         word_reg <= data_out;
   end
   // Released bus shows inverted data, so a stale sample cannot match
   assign data_in = (pipe_reg[1] | pipe_reg[2]) ? word_reg : ~word_reg;
endmodule

// file: sdram_init_sequencer_chk.sv
// Checker on the memory pins and access answer of the sequencer.
// Assumes it is bound to the top module.
`timescale 1ns/100ps
module init_seq_chk
   import sdram_init_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        memory_clock,
   input wire logic [3:0]  domain_chip_select_n,
   input wire logic        row_strobe_n,
   input wire logic        column_strobe_n,
   input wire logic        write_enable_n,
   input wire logic [15:0] mem_pin_addr,
   input wire logic        data_oe_n,
   input wire logic        mem_ack,
   input wire logic        mem_error,
   input wire logic        mem_ready
);
   // =========================================
   // Command decode
   wire logic [2:0] cmd = {row_strobe_n, column_strobe_n, write_enable_n};
   wire logic [3:0] cs  = domain_chip_select_n;
   AST_PRE_ALL: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd == CMD_PRECHARGE |-> mem_pin_addr[10] && cs == 4'h0) else $error("precharge not all");
   AST_REF_ALL: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd == CMD_REFRESH |-> cs == 4'h0) else $error("refresh not all");
   AST_REF_GAP: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd == CMD_REFRESH |=> (cmd != CMD_REFRESH) [*8]) else $error("refresh too soon");
   AST_ONE_DOMAIN: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd inside {CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_MODE_SET} |-> $onehot(~cs)) else $error("select");
   AST_MODE_NOPS: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd == CMD_MODE_SET |=> (cmd == CMD_NOP) [*3]) else $error("mode set gap");
   AST_READ_ACT: assert property (@(posedge memory_clock) disable iff (!reset_n)
      cmd == CMD_READ |-> $past(cmd) == CMD_ACTIVE) else $error("read without active");
   AST_OE_WRITE: assert property (@(posedge memory_clock) disable iff (!reset_n)
      !data_oe_n |-> cmd == CMD_WRITE) else $error("data driven off write");
   AST_ERR_ACK: assert property (@(posedge core_clk) disable iff (!reset_n)
      mem_error |-> mem_ack && !mem_ready) else $error("error without ack");
endmodule
bind sdram_init_sequencer init_seq_chk chk (.core_clk, .reset_n, .memory_clock, .domain_chip_select_n,
   .row_strobe_n, .column_strobe_n, .write_enable_n, .mem_pin_addr, .data_oe_n, .mem_ack, .mem_error, .mem_ready);

// file: tb_top.sv
// Testbench: power-up sequence, mode loads, normal accesses, unmapped access.
// Assumes the memory model answers on the pins.
`timescale 1ns/100ps
module tb_top
   import sdram_init_pkg::*;
;
   logic core_clk = 0, memory_clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, mem_req = 0, mem_write = 0;
   logic [7:0]  reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, mem_addr = 32'h0, mem_wdata = 32'h0, reg_rdata, mem_rdata, data_in, data_out, r;
   logic mem_ready, mem_ack, mem_error, row_strobe_n, column_strobe_n, write_enable_n, data_oe_n, e;
   logic [3:0]  domain_chip_select_n;
   logic [15:0] mem_pin_addr;
   logic [31:0] mode_seen = 32'h0;
   int          refs = 0, pres = 0, checks = 0, failures = 0;
   wire  logic [2:0] cmd = {row_strobe_n, column_strobe_n, write_enable_n};
   sdram_init_sequencer dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ready, .mem_ack, .mem_error, .mem_rdata, .memory_clock,
      .domain_chip_select_n, .row_strobe_n, .column_strobe_n, .write_enable_n, .mem_pin_addr, .data_in,
      .data_out, .data_oe_n);
   mem_model mem (.memory_clock, .domain_chip_select_n, .cmd, .data_out, .data_oe_n, .data_in);
   // =========================================
   // Clocks; the memory clock is offset so the phases never line up
   initial forever #20 core_clk = ~core_clk;
   initial
   begin
      #3;
      forever #7.5 memory_clock = ~memory_clock;
   end
   // Pin monitor, sampled mid-cycle
   always @(negedge memory_clock)
   begin
      if (cmd == CMD_REFRESH) refs++;
      if (cmd == CMD_PRECHARGE) pres++;
      if (cmd == CMD_MODE_SET) mode_seen = {12'h0, domain_chip_select_n, mem_pin_addr};
   end
   // =========================================
   // Tasks
   task chk(input string n, input logic [31:0] x, g);
      checks++;
      if (g !== x)
      begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, x, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge core_clk);
      reg_write <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input string n);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge core_clk);
      reg_read <= 1'h0;
      @(negedge core_clk);
      chk(n, x, reg_rdata);
   endtask
   // One access; request held until the edge that takes it
   task automatic acc(input logic w, input logic [31:0] a, d);
      int n = 0;
      @(posedge core_clk);
      mem_write <= w;
      mem_addr <= a;
      mem_wdata <= d;
      mem_req <= 1'h1;
      do @(negedge core_clk); while (mem_ready !== 1'h1 && ++n < 60);
      @(posedge core_clk);
      mem_req <= 1'h0;
      n = 0;
      do @(negedge core_clk); while (mem_ack !== 1'h1 && ++n < 60);
      chk("ack", 32'h1, 32'(mem_ack));
      r = mem_rdata;
      e = mem_error;
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog, well past the expected 310 us
   initial
   begin
      #1000000;
      failures++;
      end_of_test;
   end
   // =========================================
   // Power-up sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'h1;
      rd(8'h00, 32'h3, "ctrl");
      repeat (2500) @(posedge core_clk);
      @(negedge memory_clock);
      chk("nop", 32'h7, 32'({domain_chip_select_n, cmd}));
      wr(8'h10, 32'h30);
      wr(8'h14, 32'h34);
      repeat (5000) @(posedge core_clk);
      wr(8'h00, 32'h1);
      wr(8'h08, 32'hB);
      repeat (60) @(posedge core_clk);
      chk("pre", 32'h1, 32'(pres));
      chk("refs", 32'h1, 32'(refs >= 14));
      wr(8'h08, 32'h100);
      wr(8'h00, 32'h2);
      repeat (10) @(posedge core_clk);
      acc(1'h0, 32'hC000C800, 32'h0);
      chk("mode0", 32'h000E0032, mode_seen);
      acc(1'h0, 32'hD0006600, 32'h0);
      chk("mode1", 32'h000D0033, mode_seen);
      wr(8'h00, 32'h0);
      repeat (10) @(posedge core_clk);
      acc(1'h1, 32'hF0000040, 32'hA5A51234);
      acc(1'h0, 32'hF0000040, 32'h0);
      chk("rd32", 32'hA5A51234, r);
      chk("err", 32'h0, 32'(e));
      acc(1'h1, 32'hD0000040, 32'h5A5A8765);
      acc(1'h0, 32'hD0000040, 32'h0);
      chk("rd16", 32'h00008765, r);
      acc(1'h0, 32'h10000000, 32'h0);
      chk("unmapped", 32'h1, 32'(e));
      rd(8'h04, 32'h4, "status");
      // Command-load mode: access completes with no memory cycle and zero data
      wr(8'h00, 32'h4);
      wr(8'h04, 32'h4);
      rd(8'h04, 32'h0, "clear");
      acc(1'h0, 32'hF0000040, 32'h0);
      chk("cmdload", 32'h0, r);
      end_of_test;
   end
endmodule
